// ---- rtl/sac_ctrl.v ----
// Serial control and readout logic of an eight-input SAR converter.
// Assumes the serial pins arrive asynchronously and are sampled by sys_clk (40 MHz),
// and that the analog SAR array answers each bit trial on cmp_result.
`timescale 1ns/10ps
`default_nettype none
`include "sac_regs.vh"
// Overview of operation
// RULE1 - Host sends command byte with bit 7 high; first high bit starts it.
// RULE2 - Ignore serial input until the lead flag is seen.
// RULE3 - Decode MSB first: lead, channel 6-4, unused 3, topology 2, power 1-0.
// RULE4 - Single-ended uses common return; otherwise a differential channel pair.
// RULE5 - Field 00: low power after conversion, instant full power on next.
// RULE6 - Field 10 selects internal conversion clock mode.
// RULE7 - Host never sends field 01; it is reserved.
// RULE8 - Field 11: always powered, external clock mode paced by serial clock.
// RULE9 - Serial clock always shifts command and result bits in both modes.
// RULE10 - Clock mode change takes effect after one extra conversion cycle.
// RULE11 - Power-down setting keeps the previous clock mode.
// RULE12 - External mode: busy high one serial clock after last command bit.
// RULE13 - External mode: result MSB first on next 16 serial clock falling edges.
// RULE14 - Host supplies at least 25 serial clocks per conversion.
// RULE15 - Next command may overlap result LSB, giving 24 clocks.
// RULE16 - With 32 clocks, zeros follow the result LSB.
// RULE17 - External mode: busy and output float while select high; busy low after select falls.
// RULE18 - Internal mode: busy low during conversion, at most 8 us.
// RULE19 - Internal mode: result held until read, readable at any slow clock rate.
// RULE20 - Host should hold serial clock low during internal conversion.
// RULE21 - Internal mode, select low at end: MSB on next falling edge, then D14-D0.
// RULE22 - Internal mode, select high at end: output floats until select falls; busy driven.
// RULE23 - Single-ended channel map: code bits reversed order give input number.
// RULE24 - Differential: low code bits pick pair, top bit picks positive input.
// RULE25 - Result is unsigned straight binary.
// RULE26 - Command bit 3 is ignored.
module sac_ctrl (
    input wire sys_clk, // System clock, 40 MHz
    input wire nrst, // Asynchronous reset, active low
    input wire select_n, // Chip select pin, active low
    input wire serial_clock_line, // Host serial clock pin
    input wire serial_in, // Host serial data pin
    input wire cmp_result, // Analog comparator decision for current trial
    output reg serial_out, // Serial result data
    output reg serial_out_oe, // Output enable of serial_out
    output reg busy, // Busy line
    output reg busy_oe, // Output enable of busy
    output reg [7:0] mux_pos_sel, // One-hot positive input select
    output reg [7:0] mux_neg_sel, // Negative input select: one-hot when differential, all zero when the common return is used
    output reg mux_neg_common, // Negative input is the common return input
    output reg [15:0] sar_trial, // Trial code driven to the capacitor array
    output reg sample_hold, // High while sampling, low in hold
    output reg low_power // Analog section in low power
);
    // Control states
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD = 3'h1;
    localparam ST_EBUSY = 3'h2;
    localparam ST_EOUT = 3'h3;
    localparam ST_ICONV = 3'h4;
    localparam ST_IDONE = 3'h5;

    wire cs_n_s;
    wire sclk_s;
    wire din_s;
    reg sclk_d;
    reg cs_d;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [6:0] cmd_sh;
    reg int_mode;
    reg [4:0] res_cnt;
    reg [15:0] result;
    reg [8:0] step_cnt;
    reg [8:0] conv_cnt;
    reg read_armed;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire [7:0] cmd_byte;
    reg [15:0] next_trial;
    reg [7:0] next_pos_sel;
    reg [7:0] next_neg_sel;
    wire [2:0] se_index;
    wire [2:0] df_pos;
    wire [2:0] df_neg;
    wire [1:0] held_pc;
    wire step_due;
    wire last_step;
    wire ext_conv;

    // Pin synchronisers
    sac_sync u_cs (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rst_val(1'b1),
        .din(select_n),
        .dout(cs_n_s)
    );
    sac_sync u_ck (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rst_val(1'b0),
        .din(serial_clock_line),
        .dout(sclk_s)
    );
    sac_sync u_di (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .rst_val(1'b0),
        .din(serial_in),
        .dout(din_s)
    );

    // Edge detection on synchronised levels
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_n_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s; // RULE9
    assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s; // RULE9
    assign cs_fall = ~cs_n_s & cs_d;
    assign cmd_byte = {cmd_sh, din_s};
    // Field views: power/clock of the byte in force, step timing
    assign held_pc = cmd_sh[`SAC_PC_HI:`SAC_PC_LO];
    assign step_due = (step_cnt == `SAC_STEP_CYC);
    assign last_step = (res_cnt == `SAC_RES_BITS - 5'h01) || (conv_cnt == `SAC_CONV_LAST); // RULE18
    assign ext_conv = (state == ST_EBUSY) || (state == ST_EOUT);

    // Channel numbers while the topology bit is on serial_in; bit 3 ignored
    assign se_index = {cmd_sh[1], cmd_sh[2], cmd_sh[3]}; // RULE23 RULE26
    assign df_pos = {cmd_sh[2], cmd_sh[1], cmd_sh[3]}; // RULE24
    assign df_neg = {cmd_sh[2], cmd_sh[1], ~cmd_sh[3]}; // RULE24

    // One-hot positive select for either topology, one-hot negative select when differential
    always @* begin
        next_pos_sel = 8'h01;
        next_neg_sel = 8'h00;
        if (din_s) begin
            next_pos_sel = 8'h01 << se_index; // RULE4
        end else begin
            next_pos_sel = 8'h01 << df_pos;
            next_neg_sel = 8'h01 << df_neg;
        end
    end

    // Next trial code: keep this decision, try the next lower bit
    always @* begin
        next_trial = (sar_trial & ~(`SAC_TRIAL_MSB >> res_cnt[3:0]))
            | ({15'h0000, cmp_result} << (`SAC_RES_MSB - res_cnt[3:0]))
            | (`SAC_TRIAL_NEXT >> res_cnt[3:0]);
    end

    // Main sequencer: command capture, conversion and readout
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            cmd_sh <= 7'h00;
            int_mode <= `SAC_MODE_RST;
            res_cnt <= 5'h00;
            result <= `SAC_RESULT_RST;
            step_cnt <= 9'h000;
            conv_cnt <= 9'h000;
            read_armed <= 1'b0;
            sar_trial <= `SAC_RESULT_RST;
            sample_hold <= 1'b0;
            low_power <= 1'b1;
            serial_out <= 1'b0;
        end else begin
            // Command capture runs in idle and during readout, allowing overlap
            if (sclk_rise && (state == ST_IDLE || state == ST_EOUT || state == ST_IDONE)) begin // RULE15
                if (din_s) begin
                    state <= ST_CMD; // RULE2
                    bit_cnt <= 3'h1;
                    cmd_sh <= 7'h01; // RULE1
                    sample_hold <= 1'b1;
                    low_power <= 1'b0; // RULE5
                end
            end else if (sclk_rise && state == ST_CMD) begin
                cmd_sh <= cmd_byte[6:0]; // RULE3
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == `SAC_CMD_BITS) begin
                    sample_hold <= 1'b0;
                    sar_trial <= `SAC_TRIAL_MSB;
                    if (cmd_byte[`SAC_PC_HI:`SAC_PC_LO] == `SAC_PC_AUTO_PD) begin
                        low_power <= 1'b0; // RULE11
                    end else begin
                        int_mode <= ~cmd_byte[`SAC_PC_LO]; // RULE6 RULE8 RULE10
                    end
                    // Mode in force is the one held before this byte
                    if (int_mode) begin
                        state <= ST_ICONV; // RULE18
                        res_cnt <= 5'h00;
                        step_cnt <= 9'h000;
                        conv_cnt <= 9'h000;
                    end else begin
                        state <= ST_EBUSY; // RULE12
                    end
                end
            end

            // External clock conversion: one step per falling edge
            if (state == ST_EBUSY && sclk_fall) begin
                state <= ST_EOUT;
                res_cnt <= 5'h00;
            end
            if (state == ST_EOUT && sclk_fall) begin
                if (res_cnt < `SAC_RES_BITS) begin
                    serial_out <= cmp_result; // RULE13 RULE25
                    result[`SAC_RES_MSB - res_cnt[3:0]] <= cmp_result;
                    sar_trial <= next_trial;
                    res_cnt <= res_cnt + 5'h01;
                end else begin
                    serial_out <= 1'b0; // RULE16
                    if (held_pc == `SAC_PC_AUTO_PD) begin
                        low_power <= 1'b1; // RULE5
                    end
                end
            end

            // Internal conversion: paced by sys_clk steps
            if (state == ST_ICONV) begin
                conv_cnt <= conv_cnt + 9'h001;
                step_cnt <= step_cnt + 9'h001;
                if (step_due) begin
                    step_cnt <= 9'h000;
                    result[`SAC_RES_MSB - res_cnt[3:0]] <= cmp_result;
                    sar_trial <= next_trial;
                    res_cnt <= res_cnt + 5'h01;
                    if (last_step) begin
                        state <= ST_IDONE; // RULE18
                        res_cnt <= 5'h00;
                        read_armed <= ~cs_n_s; // RULE21 RULE22
                        if (held_pc == `SAC_PC_AUTO_PD) begin
                            low_power <= 1'b1; // RULE5
                        end
                    end
                end
            end

            // Internal mode readout from held register
            if (state == ST_IDONE) begin
                if (cs_fall) begin
                    read_armed <= 1'b1; // RULE22
                end
                if (sclk_fall && read_armed && res_cnt < `SAC_RES_BITS) begin
                    serial_out <= result[`SAC_RES_MSB - res_cnt[3:0]]; // RULE19 RULE21
                    res_cnt <= res_cnt + 5'h01;
                end else if (sclk_fall && read_armed) begin
                    serial_out <= 1'b0;
                end
            end
        end
    end

    // Busy level: low in internal conversion, one pulse in external conversion
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else if (state == ST_ICONV) begin
            busy <= 1'b0; // RULE18
        end else if (ext_conv) begin
            busy <= (state == ST_EBUSY); // RULE12
        end else begin
            busy <= int_mode;
        end
    end

    // Busy enable: always in internal mode except during an external conversion, else only while selected
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_oe <= 1'b0;
        end else begin
            busy_oe <= (int_mode && !ext_conv) ? 1'b1 : ~cs_n_s; // RULE17 RULE22
        end
    end

    // Result enable: internal readout waits for an armed select
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            serial_out_oe <= 1'b0;
        end else if (state == ST_IDONE || state == ST_ICONV) begin
            serial_out_oe <= ~cs_n_s & read_armed; // RULE22
        end else begin
            serial_out_oe <= ~cs_n_s; // RULE17
        end
    end

    // Multiplexer decode from latched command
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mux_pos_sel <= 8'h01;
            mux_neg_sel <= 8'h00;
            mux_neg_common <= 1'b1;
        end else if (sclk_rise && state == ST_CMD && bit_cnt == `SAC_TOPO_CNT) begin
            // Taken on the rising edge that carries the topology bit
            mux_pos_sel <= next_pos_sel; // RULE23 RULE24
            mux_neg_sel <= next_neg_sel; // RULE24
            mux_neg_common <= din_s; // RULE4
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sac_regs.vh ----
// Constants for the serial control and readout logic of the converter.
// Assumes inclusion by the design files under rtl/.
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// Command byte field positions
`define SAC_LEAD_BIT 7
`define SAC_CH_HI 6
`define SAC_CH_LO 4
`define SAC_TOPO_BIT 2
`define SAC_PC_HI 1
`define SAC_PC_LO 0
// Power/clock field codes
`define SAC_PC_AUTO_PD 2'h0
`define SAC_PC_RSVD 2'h1
`define SAC_PC_INT 2'h2
`define SAC_PC_EXT 2'h3
// Counts
`define SAC_CMD_BITS 4'h7
`define SAC_RES_BITS 5'h10
`define SAC_RES_MSB 4'hF
// Internal conversion: 8 us at 40 MHz, longest time rounds down
`define SAC_CLK_MHZ 40
`define SAC_CONV_US 8
`define SAC_CONV_CYC (`SAC_CONV_US * `SAC_CLK_MHZ)
// Last step counter value of an internal conversion step (20 sys_clk per step, 16 steps fit in 8 us)
`define SAC_STEP_CYC 9'h013
// Last sys_clk cycle of the internal conversion window
`define SAC_CONV_LAST 9'h13F
// First trial bit and the one tried after it
`define SAC_TRIAL_MSB 16'h8000
`define SAC_TRIAL_NEXT 16'h4000
// Command bits already taken when the topology bit arrives
`define SAC_TOPO_CNT 3'h5
// Reset values
`define SAC_MODE_RST 1'b0
`define SAC_RESULT_RST 16'h0000
`endif

// ---- rtl/sac_sync.v ----
// Two flip-flop synchroniser for one asynchronous level.
// Assumes sys_clk and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module sac_sync (
    input wire sys_clk, // System clock
    input wire nrst, // Asynchronous reset, active low
    input wire rst_val, // Reset level input, not used; reset loads 0 into both stages
    input wire din, // Asynchronous input
    output reg dout // Synchronised level
);
    reg stage1;

    // First stage read only by the second
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sac_host.sv ----
// Host model: select, serial clock and command data; samples busy and result each clock.
// Assumes sys_clk at 40 MHz; one serial clock period is 8 sys_clk, clock idles low.
`timescale 1ns/10ps
`default_nettype none
module sac_host (
    input wire logic sys_clk, // System clock
    input wire logic sdo, // Result pin level
    input wire logic busy, // Busy pin level
    output logic select_n, // Chip select, active low
    output logic sclk, // Serial clock
    output logic sdi // Command data
);
    // Idle: deselected, clock low
    initial begin
        select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Move select, then let the pins settle
    task sel(input logic v);
        @(posedge sys_clk) select_n <= v;
        repeat (8) @(posedge sys_clk);
    endtask
    // Clock n bits of pat MSB first; b and d collect busy and result per clock
    task shift(input logic [63:0] pat, input int n, output logic [63:0] d, output logic [63:0] b);
        d = 64'h0000;
        b = 64'h0000;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk) sclk <= 1'b0;
            sdi <= pat[63 - i];
            repeat (2) @(posedge sys_clk);
            b = {b[62:0], busy};
            repeat (2) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            d = {d[62:0], sdo};
            @(posedge sys_clk);
        end
        @(posedge sys_clk) sclk <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/sac_ctrl_assertions.sv ----
// Checker on the control pins: reset state, input selection, pin enables, edge timing.
// Assumes binding to sac_ctrl and a serial clock period of at least 8 sys_clk.
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl_chk (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Reset, active low
    input wire logic select_n, // Chip select, active low
    input wire logic serial_clock_line, // Serial clock pin
    input wire logic serial_out, // Result data
    input wire logic serial_out_oe, // Result enable
    input wire logic busy, // Busy line
    input wire logic busy_oe, // Busy enable
    input wire logic [7:0] mux_pos_sel, // Positive input
    input wire logic [7:0] mux_neg_sel, // Negative input
    input wire logic mux_neg_common, // Common return in use
    input wire logic low_power // Low power
);
    logic clk_q;
    logic [8:0] since_rise;
    logic [8:0] since_fall;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Cycles since the last serial clock edges, saturating
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clk_q <= 1'b0;
            since_rise <= 9'h1FF;
            since_fall <= 9'h1FF;
        end else begin
            clk_q <= serial_clock_line;
            since_rise <= (serial_clock_line && !clk_q) ? 9'h000 : since_rise + {8'h00, since_rise != 9'h1FF};
            since_fall <= (!serial_clock_line && clk_q) ? 9'h000 : since_fall + {8'h00, since_fall != 9'h1FF};
        end
    end
    sequence s_busy_hold;
        busy [*3];
    endsequence
    sequence s_deselected;
        select_n [*8];
    endsequence
    a_reset_state: assert property (disable iff (1'b0) !nrst && $past(!nrst) |-> mux_pos_sel == 8'h01 && mux_neg_common
        && low_power && !busy_oe && !serial_out_oe) else $error("outputs wrong during reset");
    a_pos_onehot: assert property ($onehot(mux_pos_sel)) else $error("positive select not one-hot");
    a_diff_pair: assert property (!mux_neg_common |-> $onehot(mux_neg_sel) &&
        (mux_pos_sel | mux_neg_sel) inside {8'h03, 8'h0C, 8'h30, 8'hC0}) else $error("bad differential pair");
    a_out_float: assert property (s_deselected |-> !serial_out_oe) else $error("data driven while deselected");
    a_busy_enable: assert property ($fell(select_n) |-> ##[1:8] busy_oe) else $error("busy not driven");
    a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
        |-> since_fall <= 9'h006) else $error("data changed away from a falling edge");
    a_busy_rise: assert property ($rose(busy) |-> since_rise <= 9'h006 || since_rise >= 9'h12C)
        else $error("busy rose at a wrong time");
    a_busy_pulse: assert property ($rose(busy) |-> s_busy_hold) else $error("busy pulse too short");
endmodule
bind sac_ctrl sac_ctrl_chk i_sac_ctrl_chk (.sys_clk, .nrst, .select_n, .serial_clock_line, .serial_out,
    .serial_out_oe, .busy, .busy_oe, .mux_pos_sel, .mux_neg_sel, .mux_neg_common, .low_power);
`default_nettype wire

// ---- tb/tb.sv ----
// Top bench: host and comparator models drive the control logic; results are checked.
// Assumes sac_ctrl with its checker bound; serial clock period 200 ns.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cmp = 1'b0;
    logic [15:0] target = 16'h0000;
    wire select_n, sclk, sdi, so, so_oe, bz, bz_oe, nc, lp;
    wire [7:0] ps, ns;
    wire [15:0] tr;
    int bad_count = 0;
    int n_checks = 0;
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    // Comparator keeps a trial bit while the trial does not exceed the input
    always @(posedge sys_clk) cmp <= (tr <= target);
    sac_ctrl i_sac_ctrl (.sys_clk(sys_clk), .nrst(nrst), .select_n(select_n), .serial_clock_line(sclk),
        .serial_in(sdi), .cmp_result(cmp), .serial_out(so), .serial_out_oe(so_oe), .busy(bz), .busy_oe(bz_oe),
        .mux_pos_sel(ps), .mux_neg_sel(ns), .mux_neg_common(nc), .sar_trial(tr), .sample_hold(), .low_power(lp));
    // Released pins show the inverse of their last value
    sac_host i_sac_host (.sys_clk(sys_clk), .sdo(so_oe ? so : ~so), .busy(bz_oe ? bz : ~bz),
        .select_n(select_n), .sclk(sclk), .sdi(sdi));
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Expected {common, negative, positive} input selection
    function automatic logic [16:0] mux_exp(input logic [7:0] c);
        logic [7:0] lo;
        lo = 8'h01 << {c[5:4], 1'b0};
        if (c[2]) return {1'b1, 8'h00, 8'h01 << {c[4], c[5], c[6]}};
        return c[6] ? {1'b0, lo, lo << 1} : {1'b0, lo << 1, lo};
    endfunction
    // Main sequence
    initial begin
        logic [63:0] d, b;
        logic [7:0] c;
        int k, w;
        k = $urandom(80);
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // External mode, 32 clocks, leading zeros, random channel and unused bit
        for (int i = 0; i < 8; i++) begin
            k = i % 3;
            target <= 16'($urandom);
            c = {1'b1, 3'($urandom), 1'($urandom), 1'($urandom), (i % 2) ? 2'h0 : 2'h3};
            i_sac_host.sel(1'b0);
            i_sac_host.shift({c, 56'h0000} >> k, 32 + k, d, b);
            chk(d[22:0], {target, 7'h00});
            chk(b[31:0], 32'h0080_0000);
            chk({nc, c[2] ? 8'h00 : ns, ps}, mux_exp(c));
            chk(lp, c[1:0] == 2'h0);
            i_sac_host.sel(1'b1);
            chk({so_oe, bz_oe}, 2'h0);
        end
        // Overlapped commands, 24 clocks for the first conversion, 25 for the second
        c = 8'hD3;
        i_sac_host.sel(1'b0);
        i_sac_host.shift({8'hB7, 16'h0000, c, 32'h0000}, 49, d, b);
        chk({d[39:24], d[15:0]}, {target, target});
        chk({nc, ns, ps}, mux_exp(c));
        // Mode switch command still converts with the external clock
        c = 8'hA6;
        i_sac_host.shift({c, 56'h0000}, 32, d, b);
        chk(d[22:7], target);
        chk(b[31:0], 32'h0080_0000);
        // Internal mode, select held low and then raised during conversion
        for (int j = 0; j < 2; j++) begin
            target <= 16'($urandom);
            i_sac_host.shift({c, 56'h0000}, 8, d, b);
            if (j) i_sac_host.sel(1'b1);
            w = 0;
            while (bz !== 1'b1 && w < 400) begin
                @(posedge sys_clk);
                w++;
            end
            if (w >= 400) begin
                bad_count++;
                tally_and_finish();
            end
            chk(w > 0 && w <= 320, 1'b1);
            repeat (50) @(posedge sys_clk);
            if (j) begin
                chk({so_oe, bz_oe}, 2'h1);
                i_sac_host.sel(1'b0);
            end
            i_sac_host.shift(64'h0000, 17, d, b);
            chk(d[15:0], target);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
